// ---- rtl/pll_cfg_consts.svh ----
/*
  Holds the addresses, field positions, writable-bit masks and reset values of the
  analog PLL and power-down configuration bytes.
  Assumes it is included by bare name from design files that need these numbers.
*/
`ifndef PLL_CFG_CONSTS_SVH
`define PLL_CFG_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses on the serial configuration port
// ----------------------------------------------------------------
`define ADDR_APLL_FILTER_PUMP_CFG 16'h00ac
`define ADDR_APLL_MODE_LOCK_CFG 16'h00ad
`define ADDR_VCO_ONE_MANUAL_LOCK 16'h00ae
`define ADDR_VCO_TWO_MANUAL_LOCK 16'h00af
`define ADDR_POWER_DOWN_RESERVED 16'h00b4
`define ADDR_INPUT_REF_DISABLE 16'h00b5
`define ADDR_POWER_DOWN_FIXED 16'h00b6
`define ADDR_OUTPUT_DISABLE 16'h00b7
`define ADDR_PLL_BLOCK_DISABLE 16'h00b8

// ----------------------------------------------------------------
// field positions (lowest bit of each field)
// ----------------------------------------------------------------
`define POS_PUMP_CURRENT 5
`define POS_SERIES_RES 3
`define POS_PARALLEL_CAP 1
`define POS_SECOND_POLE 0
`define POS_SYNTH_MODE 3
`define POS_LOCK_COUNT 1
`define POS_LOCK_OVERRIDE 0
`define POS_VCO_CHOICE 5
`define POS_LOCK_VALUE 0
`define POS_INPUT_REF 0
`define POS_DOUBLER_OFF 4
`define POS_DIGITAL_LOOP_OFF 2
`define POS_CAL_HOLD 0

// ----------------------------------------------------------------
// writable bits per register; everything else is reserved
// ----------------------------------------------------------------
`define MASK_APLL_FILTER_PUMP_CFG 8'hff
`define MASK_APLL_MODE_LOCK_CFG 8'h0b
`define MASK_VCO_ONE_MANUAL_LOCK 8'h3f
`define MASK_VCO_TWO_MANUAL_LOCK 8'h1f
`define MASK_INPUT_REF_DISABLE 8'h03
`define MASK_POWER_DOWN_FIXED 8'h10
`define MASK_OUTPUT_DISABLE 8'hff
`define MASK_PLL_BLOCK_DISABLE 8'h05

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_APLL_FILTER_PUMP_CFG 8'h8b
`define RST_APLL_MODE_LOCK_CFG 8'h02
`define RST_VCO_ONE_MANUAL_LOCK 8'h2b
`define RST_VCO_TWO_MANUAL_LOCK 8'h00
`define RST_INPUT_REF_DISABLE 8'h00
`define RST_POWER_DOWN_FIXED 8'h00
`define RST_OUTPUT_DISABLE 8'h00
`define RST_PLL_BLOCK_DISABLE 8'h00

`endif

// ---- rtl/pll_cfg_pkg.sv ----
/*
  Types shared by the PLL configuration register bank.
  Assumes nothing of its surroundings.
*/
package pll_cfg_pkg;
  typedef logic [7:0] cfg_byte_t;
  typedef logic [15:0] cfg_addr_t;
  // analog PLL lock control
  typedef enum logic {
    LOCK_AUTO,
    LOCK_MANUAL
  } lock_mode_t;
endpackage

// ---- rtl/cfg_byte_reg.sv ----
/*
  One configuration byte: stores only its writable bits, reserved bits stay zero.
  Assumes a write strobe on the same clock, one cycle wide per write.
*/
`timescale 1ns/1ps

module cfg_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] value_ff
);

  logic [7:0] nxt_value;

  // reserved positions never store what software writes
  assign nxt_value = wr_en ? (wdata & WRITE_MASK) : value_ff;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_ff <= RESET_VALUE & WRITE_MASK;
    end else begin
      value_ff <= nxt_value;
    end
  end

endmodule

// ---- rtl/pll_config_power_down_regs.sv ----
/*
  Analog PLL configuration and power-down register bank. Byte registers written and read
  over the device's serial configuration port; every stored field drives a static control.
  Assumes the serial port engine runs on clk and presents one address with a one-cycle
  write or read strobe; the analog PLL, digital PLL, inputs and outputs consume the levels.
*/
// Function
// - 3-bit pump current code, 110 uA steps, resets to 100b.
// - 2-bit loop filter series resistor select, resets to 01b.
// - 2-bit loop filter parallel capacitor select, resets to 01b.
// - second-pole select bit for post filter, resets to 1.
// - lock count accuracy bit, 0 is 1 ppm, 1 is 16 ppm, resets 1.
// - lock override bit, 0 automatic, 1 manual, resets automatic.
// - manual VCO choice, 0 second VCO, 1 first VCO, resets 1.
// - 5-bit first VCO manual lock value, applied in manual mode, resets 01011b.
// - 5-bit second VCO manual lock value, applied in manual mode, resets 0.
// - synthesizer mode bit: 0 translate references, 1 crystal-only synthesis.
// - crystal doubler off bit, 0 doubles crystal, resets 0.
// - one disable bit per input reference, both reset enabled.
// - eight output disable bits in one byte, set disables output.
// - digital loop disable bit, resets enabled.
// - calibration hold bit, 1 disables analog calibration, resets 0.
// - reserved bits written zero; reads of them give zero here.
`timescale 1ns/1ps
`include "pll_cfg_consts.svh"

module pll_config_power_down_regs (
  input wire logic clk,
  input wire logic rst,
  input wire pll_cfg_pkg::cfg_addr_t reg_addr,
  input wire pll_cfg_pkg::cfg_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pll_cfg_pkg::cfg_byte_t reg_rdata,
  output logic reg_rdata_valid,
  output logic reg_hit,
  output logic [2:0] pump_current_sel,
  output logic [1:0] series_resistor_sel,
  output logic [1:0] parallel_cap_sel,
  output logic second_pole_sel,
  output logic synthesizer_mode,
  output logic lock_count_accuracy,
  output logic lock_manual_override,
  output logic manual_vco_choice,
  output logic [4:0] vco_one_lock_value,
  output logic [4:0] vco_two_lock_value,
  output logic manual_lock_apply,
  output logic [4:0] manual_lock_value,
  output logic crystal_doubler_off,
  output logic [1:0] input_ref_off,
  output logic [7:0] output_off,
  output logic digital_loop_off,
  output logic calibration_hold
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam int NUM_REGS = 8;

  logic [NUM_REGS-1:0] sel;
  logic [NUM_REGS-1:0] wr_sel;
  logic [7:0] reg_value [NUM_REGS];
  logic sel_reserved;

  // one select per stored byte; the all-reserved byte decodes but stores nothing
  assign sel[0] = (reg_addr == `ADDR_APLL_FILTER_PUMP_CFG);
  assign sel[1] = (reg_addr == `ADDR_APLL_MODE_LOCK_CFG);
  assign sel[2] = (reg_addr == `ADDR_VCO_ONE_MANUAL_LOCK);
  assign sel[3] = (reg_addr == `ADDR_VCO_TWO_MANUAL_LOCK);
  assign sel[4] = (reg_addr == `ADDR_INPUT_REF_DISABLE);
  assign sel[5] = (reg_addr == `ADDR_POWER_DOWN_FIXED);
  assign sel[6] = (reg_addr == `ADDR_OUTPUT_DISABLE);
  assign sel[7] = (reg_addr == `ADDR_PLL_BLOCK_DISABLE);
  assign sel_reserved = (reg_addr == `ADDR_POWER_DOWN_RESERVED);
  assign wr_sel = sel & {NUM_REGS{reg_wr}};
  // tells the port engine the address belongs to this bank
  assign reg_hit = (|sel) | sel_reserved;

  // ----------------------------------------------------------------
  // storage bytes
  // ----------------------------------------------------------------
  // defaults at reset
  cfg_byte_reg #(
    .RESET_VALUE(`RST_APLL_FILTER_PUMP_CFG),
    .WRITE_MASK(`MASK_APLL_FILTER_PUMP_CFG)
  ) u_filter_pump (
    .clk(clk), .rst(rst), .wr_en(wr_sel[0]), .wdata(reg_wdata), .value_ff(reg_value[0])
  );
  cfg_byte_reg #(
    .RESET_VALUE(`RST_APLL_MODE_LOCK_CFG),
    .WRITE_MASK(`MASK_APLL_MODE_LOCK_CFG)
  ) u_mode_lock (
    .clk(clk), .rst(rst), .wr_en(wr_sel[1]), .wdata(reg_wdata), .value_ff(reg_value[1])
  );
  cfg_byte_reg #(
    .RESET_VALUE(`RST_VCO_ONE_MANUAL_LOCK),
    .WRITE_MASK(`MASK_VCO_ONE_MANUAL_LOCK)
  ) u_vco_one (
    .clk(clk), .rst(rst), .wr_en(wr_sel[2]), .wdata(reg_wdata), .value_ff(reg_value[2])
  );
  cfg_byte_reg #(
    .RESET_VALUE(`RST_VCO_TWO_MANUAL_LOCK),
    .WRITE_MASK(`MASK_VCO_TWO_MANUAL_LOCK)
  ) u_vco_two (
    .clk(clk), .rst(rst), .wr_en(wr_sel[3]), .wdata(reg_wdata), .value_ff(reg_value[3])
  );
  cfg_byte_reg #(
    .RESET_VALUE(`RST_INPUT_REF_DISABLE),
    .WRITE_MASK(`MASK_INPUT_REF_DISABLE)
  ) u_input_ref (
    .clk(clk), .rst(rst), .wr_en(wr_sel[4]), .wdata(reg_wdata), .value_ff(reg_value[4])
  );
  cfg_byte_reg #(
    .RESET_VALUE(`RST_POWER_DOWN_FIXED),
    .WRITE_MASK(`MASK_POWER_DOWN_FIXED)
  ) u_pd_fixed (
    .clk(clk), .rst(rst), .wr_en(wr_sel[5]), .wdata(reg_wdata), .value_ff(reg_value[5])
  );
  cfg_byte_reg #(
    .RESET_VALUE(`RST_OUTPUT_DISABLE),
    .WRITE_MASK(`MASK_OUTPUT_DISABLE)
  ) u_output_dis (
    .clk(clk), .rst(rst), .wr_en(wr_sel[6]), .wdata(reg_wdata), .value_ff(reg_value[6])
  );
  cfg_byte_reg #(
    .RESET_VALUE(`RST_PLL_BLOCK_DISABLE),
    .WRITE_MASK(`MASK_PLL_BLOCK_DISABLE)
  ) u_block_dis (
    .clk(clk), .rst(rst), .wr_en(wr_sel[7]), .wdata(reg_wdata), .value_ff(reg_value[7])
  );

  // ----------------------------------------------------------------
  // field outputs, all straight from the stored bytes
  // ----------------------------------------------------------------
  // pump current code
  assign pump_current_sel = reg_value[0][`POS_PUMP_CURRENT +: 3];
  assign series_resistor_sel = reg_value[0][`POS_SERIES_RES +: 2];
  assign parallel_cap_sel = reg_value[0][`POS_PARALLEL_CAP +: 2];
  assign second_pole_sel = reg_value[0][`POS_SECOND_POLE];
  assign synthesizer_mode = reg_value[1][`POS_SYNTH_MODE];
  assign lock_count_accuracy = reg_value[1][`POS_LOCK_COUNT];
  assign lock_manual_override = reg_value[1][`POS_LOCK_OVERRIDE];
  assign manual_vco_choice = reg_value[2][`POS_VCO_CHOICE];
  assign vco_one_lock_value = reg_value[2][`POS_LOCK_VALUE +: 5];
  assign vco_two_lock_value = reg_value[3][`POS_LOCK_VALUE +: 5];
  assign crystal_doubler_off = reg_value[5][`POS_DOUBLER_OFF];
  assign input_ref_off = reg_value[4][`POS_INPUT_REF +: 2];
  // output disables, bit n for output n
  assign output_off = reg_value[6];
  assign digital_loop_off = reg_value[7][`POS_DIGITAL_LOOP_OFF];
  assign calibration_hold = reg_value[7][`POS_CAL_HOLD];

  // ----------------------------------------------------------------
  // manual lock steering
  // ----------------------------------------------------------------
  pll_cfg_pkg::lock_mode_t lock_mode;

  // the chosen VCO's value goes out only in manual mode; zero otherwise so that the
  // analog side never sees a stale manual code while its own search runs
  assign lock_mode = lock_manual_override ? pll_cfg_pkg::LOCK_MANUAL : pll_cfg_pkg::LOCK_AUTO;
  assign manual_lock_apply = (lock_mode == pll_cfg_pkg::LOCK_MANUAL);
  assign manual_lock_value = !manual_lock_apply ? 5'h00 :
                             manual_vco_choice ? vco_one_lock_value : vco_two_lock_value;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  pll_cfg_pkg::cfg_byte_t rd_mux;
  pll_cfg_pkg::cfg_byte_t nxt_rdata;
  pll_cfg_pkg::cfg_byte_t rdata_ff;
  logic rvalid_ff;

  // one-hot select of stored bytes; reserved bits are stored as zero so they read zero
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (sel[i]) begin
        rd_mux = rd_mux | reg_value[i];
      end
    end
  end

  assign nxt_rdata = reg_rd ? rd_mux : rdata_ff;

  // data holds until the next read so the port engine may sample late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= reg_rd;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rdata_valid = rvalid_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence wr_pump_s;
    reg_wr && (reg_addr == `ADDR_APLL_FILTER_PUMP_CFG);
  endsequence

  sequence wr_outdis_s;
    reg_wr && (reg_addr == `ADDR_OUTPUT_DISABLE);
  endsequence

  sequence rd_any_s;
    reg_rd;
  endsequence

  pump_write_load_a: assert property (@(posedge clk) disable iff (rst)
    wr_pump_s |=> pump_current_sel == $past(reg_wdata[7:5]))
    else $error("pump current did not take written code");

  filter_write_load_a: assert property (@(posedge clk) disable iff (rst)
    wr_pump_s |=> {series_resistor_sel, parallel_cap_sel, second_pole_sel} == $past(reg_wdata[4:0]))
    else $error("filter fields did not take written value");

  outdis_hold_a: assert property (@(posedge clk) disable iff (rst)
    wr_outdis_s ##1 (!reg_wr)[*3] |-> output_off == $past(reg_wdata, 3))
    else $error("output disable byte lost its value");

  manual_lock_mux_a: assert property (@(posedge clk) disable iff (rst)
    (lock_manual_override && manual_vco_choice) |-> manual_lock_value == vco_one_lock_value)
    else $error("manual mode did not apply first VCO value");

  manual_lock_two_a: assert property (@(posedge clk) disable iff (rst)
    (lock_manual_override && !manual_vco_choice) |-> manual_lock_value == vco_two_lock_value)
    else $error("manual mode did not apply second VCO value");

  auto_no_apply_a: assert property (@(posedge clk) disable iff (rst)
    !lock_manual_override |-> (!manual_lock_apply && manual_lock_value == 5'h00))
    else $error("manual lock value applied in automatic mode");

  rsvd_read_zero_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `ADDR_APLL_MODE_LOCK_CFG) |=> (reg_rdata & 8'hf4) == 8'h00)
    else $error("reserved bits of mode byte read nonzero");

  rsvd_byte_zero_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `ADDR_POWER_DOWN_RESERVED) |=> reg_rdata == 8'h00)
    else $error("reserved byte read nonzero");

  // read returns stored value one cycle on
  read_timing_a: assert property (@(posedge clk) disable iff (rst)
    rd_any_s |=> reg_rdata_valid && reg_rdata == $past(rd_mux) ##1 (reg_rdata_valid == $past(reg_rd)))
    else $error("read answer wrong or mistimed");

  inref_stable_a: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && reg_addr == `ADDR_INPUT_REF_DISABLE) |=> $stable(input_ref_off))
    else $error("input disables changed without a write");

  // calibration and loop disable follow write
  block_dis_load_a: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `ADDR_PLL_BLOCK_DISABLE |=>
      {digital_loop_off, calibration_hold} == {$past(reg_wdata[2]), $past(reg_wdata[0])})
    else $error("block disable bits did not load");

  reset_defaults_a: assert property (@(posedge clk)
    $fell(rst) |-> (pump_current_sel == 3'h4 && series_resistor_sel == 2'h1 && parallel_cap_sel == 2'h1
      && second_pole_sel && lock_count_accuracy && !lock_manual_override && manual_vco_choice
      && vco_one_lock_value == 5'h0b && output_off == 8'h00 && !synthesizer_mode))
    else $error("fields not at defaults after reset");

endmodule

// ---- verif/cfg_host_model.sv ----
/*
  Host side of the configuration port: issues one register access at a time.
  Assumes the register bank takes a strobe on the rising clk edge and answers one cycle later.
*/
`timescale 1ns/1ps

module cfg_host_model (
  input wire logic clk,
  output pll_cfg_pkg::cfg_addr_t reg_addr,
  output pll_cfg_pkg::cfg_byte_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire pll_cfg_pkg::cfg_byte_t reg_rdata,
  input wire logic reg_rdata_valid,
  input wire logic reg_hit
);
  // idle port at time zero
  initial begin
    reg_addr = 16'hffff;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ------------------------------------------------------------
  // one access, strobes held across exactly one taking edge
  // ------------------------------------------------------------
  // caller chooses data; reserved bits zero unless a refusal is meant
  task automatic access(input logic [15:0] addr, input logic [7:0] data, input logic wr,
                        input logic rd, output logic [7:0] rdata, output logic valid,
                        output logic hit);
    @(posedge clk);
    #1;
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = wr;
    reg_rd = rd;
    #1;
    hit = reg_hit;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released lines carry junk so nothing leans on stale values
    reg_addr = ~addr;
    reg_wdata = ~data;
    rdata = reg_rdata;
    valid = reg_rdata_valid;
  endtask
endmodule

// ---- verif/pll_config_power_down_regs_tb.sv ----
/*
  Self-checking bench for the PLL configuration and power-down register bank.
  Assumes the host model drives the port and a shadow copy predicts every field.
*/
`timescale 1ns/1ps

module pll_config_power_down_regs_tb;
  logic clk;
  logic rst;
  pll_cfg_pkg::cfg_addr_t reg_addr;
  pll_cfg_pkg::cfg_byte_t reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rdata_valid, reg_hit;
  logic [2:0] pump_current_sel;
  logic [1:0] series_resistor_sel, parallel_cap_sel, input_ref_off;
  logic second_pole_sel, synthesizer_mode, lock_count_accuracy, lock_manual_override;
  logic manual_vco_choice, manual_lock_apply, crystal_doubler_off, digital_loop_off, calibration_hold;
  logic [4:0] vco_one_lock_value, vco_two_lock_value, manual_lock_value;
  logic [7:0] output_off;
  int miscompares = 0;
  int check_count = 0;
  logic [15:0] adr [9];
  logic [7:0] msk [9];
  logic [7:0] rstv [9];
  logic [7:0] shadow [9];
  // last byte handed back by a read; the read data must stand until the next read
  logic [7:0] last_rd;

  cfg_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .reg_hit(reg_hit));

  pll_config_power_down_regs DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .reg_hit(reg_hit), .pump_current_sel(pump_current_sel), .series_resistor_sel(series_resistor_sel),
    .parallel_cap_sel(parallel_cap_sel), .second_pole_sel(second_pole_sel),
    .synthesizer_mode(synthesizer_mode), .lock_count_accuracy(lock_count_accuracy),
    .lock_manual_override(lock_manual_override), .manual_vco_choice(manual_vco_choice),
    .vco_one_lock_value(vco_one_lock_value), .vco_two_lock_value(vco_two_lock_value),
    .manual_lock_apply(manual_lock_apply), .manual_lock_value(manual_lock_value),
    .crystal_doubler_off(crystal_doubler_off), .input_ref_off(input_ref_off), .output_off(output_off),
    .digital_loop_off(digital_loop_off), .calibration_hold(calibration_hold));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------
  // comparison and verdict
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] expv);
    check_count++;
    if (seen !== expv) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic int idx_of(input logic [15:0] a);
    for (int i = 0; i < 9; i++) begin
      if (adr[i] === a) return i;
    end
    return -1;
  endfunction

  // every field output against the shadow bytes
  task automatic check_all();
    logic [4:0] mval;
    mval = shadow[1][0] ? (shadow[2][5] ? shadow[2][4:0] : shadow[3][4:0]) : 5'h00;
    chk("pump_current_sel", {5'h0, pump_current_sel}, {5'h0, shadow[0][7:5]});
    chk("series_resistor_sel", {6'h0, series_resistor_sel}, {6'h0, shadow[0][4:3]});
    chk("parallel_cap_sel", {6'h0, parallel_cap_sel}, {6'h0, shadow[0][2:1]});
    chk("second_pole_sel", {7'h0, second_pole_sel}, {7'h0, shadow[0][0]});
    chk("lock_count_accuracy", {7'h0, lock_count_accuracy}, {7'h0, shadow[1][1]});
    chk("lock_manual_override", {7'h0, lock_manual_override}, {7'h0, shadow[1][0]});
    chk("manual_lock_apply", {7'h0, manual_lock_apply}, {7'h0, shadow[1][0]});
    chk("manual_vco_choice", {7'h0, manual_vco_choice}, {7'h0, shadow[2][5]});
    chk("vco_one_lock_value", {3'h0, vco_one_lock_value}, {3'h0, shadow[2][4:0]});
    chk("vco_two_lock_value", {3'h0, vco_two_lock_value}, {3'h0, shadow[3][4:0]});
    chk("manual_lock_value", {3'h0, manual_lock_value}, {3'h0, mval});
    chk("synthesizer_mode", {7'h0, synthesizer_mode}, {7'h0, shadow[1][3]});
    chk("crystal_doubler_off", {7'h0, crystal_doubler_off}, {7'h0, shadow[6][4]});
    chk("input_ref_off", {6'h0, input_ref_off}, {6'h0, shadow[5][1:0]});
    chk("output_off", output_off, shadow[7]);
    chk("digital_loop_off", {7'h0, digital_loop_off}, {7'h0, shadow[8][2]});
    chk("calibration_hold", {7'h0, calibration_hold}, {7'h0, shadow[8][0]});
  endtask

  // one access; read sees the byte as it stood before a write in the same cycle
  task automatic do_acc(input logic [15:0] a, input logic [7:0] d, input logic wr, input logic rd);
    logic [7:0] rdat;
    logic [7:0] expd;
    logic vld;
    logic hit;
    int k;
    k = idx_of(a);
    expd = (k >= 0) ? shadow[k] : 8'h00;
    host.access(a, d, wr, rd, rdat, vld, hit);
    chk("reg_hit", {7'h0, hit}, {7'h0, (k >= 0)});
    chk("reg_rdata_valid", {7'h0, vld}, {7'h0, rd});
    if (rd) chk("reg_rdata", rdat, expd);
    else chk("reg_rdata_hold", rdat, last_rd);
    if (rd) last_rd = expd;
    if (wr && k >= 0) shadow[k] = d & msk[k];
    check_all();
  endtask

  task automatic reset_and_check(input int cycles);
    @(posedge clk);
    #1;
    rst = 1'b1;
    #1;
    for (int i = 0; i < 9; i++) shadow[i] = rstv[i];
    check_all();
    chk("reg_rdata", reg_rdata, 8'h00);
    chk("reg_rdata_valid", {7'h0, reg_rdata_valid}, 8'h00);
    last_rd = 8'h00;
    repeat (cycles) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 9; i++) do_acc(adr[i], 8'h00, 1'b0, 1'b1);
  endtask

  // ------------------------------------------------------------
  // watchdog, well past the expected run of about five hundred cycles
  // ------------------------------------------------------------
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] a;
    logic [7:0] d;
    int k;
    rst = 1'b1;
    adr = '{16'h00ac, 16'h00ad, 16'h00ae, 16'h00af, 16'h00b4, 16'h00b5, 16'h00b6, 16'h00b7, 16'h00b8};
    msk = '{8'hff, 8'h0b, 8'h3f, 8'h1f, 8'h00, 8'h03, 8'h10, 8'hff, 8'h05};
    rstv = '{8'h8b, 8'h02, 8'h2b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    void'($urandom(32'h95d8));
    reset_and_check(6);
    // refusal: all ones everywhere, reserved bits must not stick
    for (int i = 0; i < 9; i++) do_acc(adr[i], 8'hff, 1'b1, 1'b1);
    for (int i = 0; i < 9; i++) do_acc(adr[i], 8'h00, 1'b0, 1'b1);
    do_acc(16'h00b9, 8'hff, 1'b1, 1'b1);
    do_acc(16'h0000, 8'h5a, 1'b1, 1'b1);
    // every lock mode and vco choice
    do_acc(16'h00af, 8'h0a, 1'b1, 1'b0);
    for (int m = 0; m < 4; m++) begin
      do_acc(16'h00ad, {7'h0, m[0]}, 1'b1, 1'b0);
      do_acc(16'h00ae, {2'h0, m[1], 5'h15}, 1'b1, 1'b1);
    end
    // crystal-only synthesis; the paired forced free-run state lives in the digital loop bank
    do_acc(16'h00ad, 8'h08, 1'b1, 1'b1);
    do_acc(16'h00ad, 8'h02, 1'b1, 1'b1);
    // random traffic, mostly clean data, some with reserved bits set
    for (int n = 0; n < 200; n++) begin
      k = $urandom_range(0, 10);
      a = (k < 9) ? adr[k] : 16'($urandom);
      d = 8'($urandom);
      if (k < 9 && $urandom_range(0, 3) != 0) d = d & msk[k];
      do_acc(a, d, 1'($urandom), 1'($urandom));
    end
    // second reset in mid-run
    reset_and_check(2);
    report_and_stop();
  end
endmodule
